// [hdl/gspwm_pkg.sv]
package gspwm_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int CHANNELS   = 16;
   localparam int GS_W       = 16;
   localparam int SEG_W      = 7;
   localparam int SEG_POS_W  = 9;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h04;
   localparam logic [ADDR_W-1:0] GS_STAGE_BASE  = 8'h40;
   localparam logic [ADDR_W-1:0] GS_SHOWN_BASE  = 8'h80;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_FIELD_LSB    = 0;
   localparam int CTRL_FIELD_W      = 4;
   localparam int STAT_COUNT_LSB    = 0;
   localparam int STAT_STATE_LSB    = 16;
   localparam int STAT_STATE_W      = 2;
   localparam int GS_FIELD_LSB      = 0;
   localparam logic [GS_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [GS_W-1:0] COUNT_LAST  = 16'hFFFF;

   typedef struct packed {
      logic autoRepeat;
      logic timingReset;
      logic spreadMode;
      logic outputDisable;
   } gspwm_ctrl_s;

   localparam gspwm_ctrl_s CTRL_RESET = 4'h1;

   // ---------------------------------------------------------------
   // Sequencer states, Gray along hold, run, end
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_HOLD = 2'h0,
      SEQ_RUN  = 2'h1,
      SEQ_END  = 2'h3
   } gspwm_state_e;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [hdl/gspwm_channel.sv]
`timescale 1ns/1ns
`default_nettype none

module gspwm_channel (
   input  wire logic [gspwm_pkg::GS_W-1:0] grayscaleValue,
   input  wire logic [gspwm_pkg::GS_W-1:0] position,
   input  wire logic                       spreadMode,
   input  wire logic                       enable,
   output logic                            on
);

   // ---------------------------------------------------------------
   // Segment split of the period position
   // ---------------------------------------------------------------
   logic [gspwm_pkg::SEG_W-1:0]       segment;
   logic [gspwm_pkg::SEG_W-1:0]       segmentRev;
   logic [gspwm_pkg::SEG_POS_W:0]     segPos;
   logic [gspwm_pkg::SEG_POS_W:0]     segOnTime;
   logic                              extraClock;
   logic                              spreadOn;
   logic                              plainOn;

   assign segment = position[gspwm_pkg::GS_W-1 -: gspwm_pkg::SEG_W];
   assign segPos  = {1'b0, position[gspwm_pkg::SEG_POS_W-1:0]};

   // Bit reversal interleaves the extra clocks so low values still flicker evenly
   genvar b;
   generate
      for (b = 0; b < gspwm_pkg::SEG_W; b++) begin : g_rev
         assign segmentRev[b] = segment[gspwm_pkg::SEG_W-1-b];
      end
   endgenerate

   assign extraClock = segmentRev < grayscaleValue[gspwm_pkg::SEG_W-1:0];
   assign segOnTime  = {1'b0, grayscaleValue[gspwm_pkg::GS_W-1 -: gspwm_pkg::SEG_POS_W]}
                       + {9'h000, extraClock};
   assign spreadOn   = segPos < segOnTime;
   assign plainOn    = position < grayscaleValue;
   assign on         = enable & (spreadMode ? spreadOn : plainOn);

endmodule

`default_nettype wire

// [hdl/gspwm_sequencer.sv]
// Functional notes
// - One 16-bit counter steps on each grayscale clock rising edge while counting.
// - Output disable forces the counter to zero and holds it there.
// - Mode bit zero gives plain PWM, one gives segmented spread PWM.
// - Each channel's on-time per period equals clock period times its value.
// - Output disable comes up set after reset, so outputs start off.
// - All sink outputs stay off while output disable is set.
// - Shift and grayscale latch contents are undefined until written.
// - First clock edge after enable counts to one, lighting nonzero channels.
// - Plain mode: on while counter at most value, off once it exceeds.
// - A zero grayscale value never lights its channel.
// - Counting starts after disable clears or on latch with timing reset.
// - Latch strobe with timing reset gives a one-shot internal disable pulse.
// - Auto repeat restarts the period at the 65,536th grayscale clock.
// - After a period ends outputs stay off until disable pulses or restart.
// - Spread mode splits the period into 128 segments.
// - Period runs from first to 65,536th grayscale clock after enabling.
// - Spread mode gives at most 512 clocks on-time per segment.
// - Value one lights segment one; value two adds segment sixty-five.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module gspwm_sequencer (
   input  wire logic                                 sys_clk,
   input  wire logic                                 reset,
   input  wire logic                                 grayscaleRefClock,
   input  wire logic                                 latchStrobe,
   output logic [gspwm_pkg::CHANNELS-1:0]            sinkOutput,
   input  wire logic [gspwm_pkg::ADDR_W-1:0]         s_axi_awaddr,
   input  wire logic                                 s_axi_awvalid,
   output logic                                      s_axi_awready,
   input  wire logic [gspwm_pkg::DATA_W-1:0]         s_axi_wdata,
   input  wire logic [gspwm_pkg::DATA_W/8-1:0]       s_axi_wstrb,
   input  wire logic                                 s_axi_wvalid,
   output logic                                      s_axi_wready,
   output logic [1:0]                                s_axi_bresp,
   output logic                                      s_axi_bvalid,
   input  wire logic                                 s_axi_bready,
   input  wire logic [gspwm_pkg::ADDR_W-1:0]         s_axi_araddr,
   input  wire logic                                 s_axi_arvalid,
   output logic                                      s_axi_arready,
   output logic [gspwm_pkg::DATA_W-1:0]              s_axi_rdata,
   output logic [1:0]                                s_axi_rresp,
   output logic                                      s_axi_rvalid,
   input  wire logic                                 s_axi_rready
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Pins are filtered by requiring two stages to agree, so the pin
   // rate must stay well below a quarter of the system clock.
   logic [2:0] refClockSync;
   logic [2:0] latchSync;
   logic       refClockLevel;
   logic       latchLevel;
   logic       refClockRise;
   logic       latchRise;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         refClockSync  <= 3'h0;
         latchSync     <= 3'h0;
         refClockLevel <= 1'b0;
         latchLevel    <= 1'b0;
      end else begin
         refClockSync <= {refClockSync[1:0], grayscaleRefClock};
         latchSync    <= {latchSync[1:0], latchStrobe};
         if (refClockSync[1] == refClockSync[2]) begin
            refClockLevel <= refClockSync[2];
         end
         if (latchSync[1] == latchSync[2]) begin
            latchLevel <= latchSync[2];
         end
      end
   end

   assign refClockRise = (refClockSync[1] == refClockSync[2]) & refClockSync[2] & ~refClockLevel;
   assign latchRise    = (latchSync[1] == latchSync[2]) & latchSync[2] & ~latchLevel;

   // ---------------------------------------------------------------
   // Control register and grayscale latches
   // ---------------------------------------------------------------
   gspwm_pkg::gspwm_ctrl_s                ctrl;
   logic [gspwm_pkg::GS_W-1:0]            gsStage [gspwm_pkg::CHANNELS];
   logic [gspwm_pkg::GS_W-1:0]            gsShown [gspwm_pkg::CHANNELS];
   logic                                  latchRestart;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   logic                                  awHeld;
   logic [gspwm_pkg::ADDR_W-1:0]          awAddrHeld;
   logic                                  wHeld;
   logic [gspwm_pkg::DATA_W-1:0]          wDataHeld;
   logic [gspwm_pkg::DATA_W/8-1:0]        wStrbHeld;
   logic                                  doWrite;
   logic                                  wrIsCtrl;
   logic                                  wrIsStage;
   logic                                  wrMapped;
   logic [3:0]                            wrIndex;

   assign s_axi_awready = ~awHeld;
   assign s_axi_wready  = ~wHeld;
   assign doWrite       = awHeld & wHeld & ~s_axi_bvalid;
   assign wrIndex       = awAddrHeld[5:2];
   assign wrIsCtrl      = awAddrHeld == gspwm_pkg::CTRL_OFS;
   assign wrIsStage     = awAddrHeld[7:6] == gspwm_pkg::GS_STAGE_BASE[7:6];
   assign wrMapped      = wrIsCtrl | wrIsStage | (awAddrHeld == gspwm_pkg::STATUS_OFS)
                          | (awAddrHeld[7:6] == gspwm_pkg::GS_SHOWN_BASE[7:6]);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddrHeld   <= 8'h00;
         wDataHeld    <= 32'h00000000;
         wStrbHeld    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= gspwm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld     <= 1'b1;
            awAddrHeld <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld     <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? gspwm_pkg::RESP_OKAY : gspwm_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl <= gspwm_pkg::CTRL_RESET;
      end else if (doWrite & wrIsCtrl & wStrbHeld[0]) begin
         ctrl <= wDataHeld[gspwm_pkg::CTRL_FIELD_LSB +: gspwm_pkg::CTRL_FIELD_W];
      end
   end

   // Grayscale data is left without reset; it is undefined until loaded
   always_ff @(posedge sys_clk) begin
      if (doWrite & wrIsStage) begin
         if (wStrbHeld[0]) begin
            gsStage[wrIndex][7:0] <= wDataHeld[7:0];
         end
         if (wStrbHeld[1]) begin
            gsStage[wrIndex][15:8] <= wDataHeld[15:8];
         end
      end
      if (latchRise) begin
         for (int i = 0; i < gspwm_pkg::CHANNELS; i++) begin
            gsShown[i] <= gsStage[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latchRestart <= 1'b0;
      end else begin
         latchRestart <= latchRise & ctrl.timingReset;
      end
   end

   // ---------------------------------------------------------------
   // Grayscale counter and period sequencer
   // ---------------------------------------------------------------
   gspwm_pkg::gspwm_state_e               state;
   gspwm_pkg::gspwm_state_e               next_state;
   logic [gspwm_pkg::GS_W-1:0]            count;
   logic [gspwm_pkg::GS_W-1:0]            next_count;
   logic [gspwm_pkg::GS_W-1:0]            position;
   logic                                  countEnable;

   always_comb begin
      next_state = state;
      next_count = count;
      if (ctrl.outputDisable) begin
         next_state = gspwm_pkg::SEQ_HOLD;
         next_count = gspwm_pkg::COUNT_RESET;
      end else if (latchRestart) begin
         next_state = gspwm_pkg::SEQ_RUN;
         next_count = gspwm_pkg::COUNT_RESET;
      end else begin
         unique case (state)
            gspwm_pkg::SEQ_HOLD: begin
               next_state = gspwm_pkg::SEQ_RUN;
            end
            gspwm_pkg::SEQ_RUN: begin
               if (refClockRise) begin
                  if (count == gspwm_pkg::COUNT_LAST) begin
                     next_count = gspwm_pkg::COUNT_RESET;
                     next_state = ctrl.autoRepeat ? gspwm_pkg::SEQ_RUN
                                                  : gspwm_pkg::SEQ_END;
                  end else begin
                     next_count = count + 16'h0001;
                  end
               end
            end
            gspwm_pkg::SEQ_END: begin
               next_state = gspwm_pkg::SEQ_END;
            end
            default: begin
               next_state = gspwm_pkg::SEQ_HOLD;
               next_count = gspwm_pkg::COUNT_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= gspwm_pkg::SEQ_HOLD;
         count <= gspwm_pkg::COUNT_RESET;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Counter value n means the n-th clock of the period is in progress
   assign position    = count - 16'h0001;
   assign countEnable = (state == gspwm_pkg::SEQ_RUN) & (count != gspwm_pkg::COUNT_RESET)
                        & ~ctrl.outputDisable;

   // ---------------------------------------------------------------
   // Channel comparators
   // ---------------------------------------------------------------
   logic [gspwm_pkg::CHANNELS-1:0] channelOn;

   genvar c;
   generate
      for (c = 0; c < gspwm_pkg::CHANNELS; c++) begin : g_ch
         gspwm_channel u_channel (
            .grayscaleValue (gsShown[c]),
            .position       (position),
            .spreadMode     (ctrl.spreadMode),
            .enable         (countEnable),
            .on             (channelOn[c])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sinkOutput <= 16'h0000;
      end else begin
         sinkOutput <= channelOn;
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   logic [gspwm_pkg::DATA_W-1:0]  rdValue;
   logic [gspwm_pkg::DATA_W-1:0]  statusWord;
   logic                          rdMapped;
   logic                          rdIsStage;
   logic                          rdIsShown;
   logic [3:0]                    rdIndex;

   assign rdIndex    = s_axi_araddr[5:2];
   assign rdIsStage  = s_axi_araddr[7:6] == gspwm_pkg::GS_STAGE_BASE[7:6];
   assign rdIsShown  = s_axi_araddr[7:6] == gspwm_pkg::GS_SHOWN_BASE[7:6];
   assign statusWord = {14'h0000, state, count};
   assign rdMapped   = rdIsStage | rdIsShown
                       | (s_axi_araddr[7:2] == gspwm_pkg::CTRL_OFS[7:2])
                       | (s_axi_araddr[7:2] == gspwm_pkg::STATUS_OFS[7:2]);
   assign rdValue    = rdIsStage ? {16'h0000, gsStage[rdIndex]}
                     : rdIsShown ? {16'h0000, gsShown[rdIndex]}
                     : (s_axi_araddr[7:2] == gspwm_pkg::CTRL_OFS[7:2]) ? {28'h0000000, ctrl}
                     : (s_axi_araddr[7:2] == gspwm_pkg::STATUS_OFS[7:2]) ? statusWord
                     : 32'h00000000;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= gspwm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdValue;
         s_axi_rresp  <= rdMapped ? gspwm_pkg::RESP_OKAY : gspwm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// [tb/gspwm_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module gspwm_properties (
   input wire logic                           sys_clk,
   input wire logic                           reset,
   input wire logic                           grayscaleRefClock,
   input wire logic                           latchStrobe,
   input wire logic [gspwm_pkg::CHANNELS-1:0] sinkOutput,
   input wire logic [gspwm_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input wire logic                           s_axi_awvalid,
   input wire logic                           s_axi_awready,
   input wire logic [gspwm_pkg::DATA_W-1:0]   s_axi_wdata,
   input wire logic [3:0]                     s_axi_wstrb,
   input wire logic                           s_axi_wvalid,
   input wire logic                           s_axi_wready,
   input wire logic                           s_axi_bvalid,
   input wire logic                           s_axi_bready,
   input wire logic [gspwm_pkg::ADDR_W-1:0]   s_axi_araddr,
   input wire logic                           s_axi_arvalid,
   input wire logic                           s_axi_arready,
   input wire logic [gspwm_pkg::DATA_W-1:0]   s_axi_rdata,
   input wire logic [1:0]                     s_axi_rresp,
   input wire logic                           s_axi_rvalid
);
   logic       disReg;
   logic       gsPrev;
   logic       latPrev;
   logic [3:0] quietCnt;
   wire logic  wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic  ctrlWr = wrTake && s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0];
   wire logic  stir   = grayscaleRefClock != gsPrev || latchStrobe != latPrev || wrTake;
   wire logic  rdBad  = s_axi_araddr >= 8'h08 && s_axi_araddr < 8'h40;
   // Quiet counter saturates, so long idle spans cost no wide logic
   always_ff @(posedge sys_clk) begin
      gsPrev  <= grayscaleRefClock;
      latPrev <= latchStrobe;
      if (reset) begin
         disReg   <= 1'b1;
         quietCnt <= 4'h0;
      end else begin
         if (ctrlWr) disReg <= s_axi_wdata[0];
         quietCnt <= stir ? 4'h0 : (quietCnt == 4'h8 ? 4'h8 : quietCnt + 4'h1);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_reset_off; $fell(reset) |-> sinkOutput == 16'h0000; endproperty
   a_reset_off: assert property (p_reset_off) else $error("outputs on after reset");
   property p_disable_off;
      disReg && $past(disReg) && $past(disReg, 2) |-> sinkOutput == 16'h0000;
   endproperty
   a_disable_off: assert property (p_disable_off) else $error("output on while disabled");
   property p_quiet_stable; quietCnt == 4'h8 |-> $stable(sinkOutput); endproperty
   a_quiet_stable: assert property (p_quiet_stable) else $error("output moved unprompted");
   // Pair is taken, then stored one edge later, so the response shows two edges on
   property p_write_answer; wrTake && !s_axi_bvalid |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
   a_write_answer: assert property (p_write_answer) else $error("write response missing");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read data missing");
   property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_refused: assert property (p_ar_refused) else $error("address taken during data");
   property p_read_unmapped;
      s_axi_arvalid && s_axi_arready && rdBad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read answered");
endmodule
bind gspwm_sequencer gspwm_properties u_props (.*);
`default_nettype wire

// [tb/gspwm_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Host side: grayscale clock and latch pulses
// ---------------------------------------------------------------
module gspwm_host_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       gsReq,
   input  wire logic       latReq,
   input  wire logic [3:0] halfPer,
   output logic            grayscaleRefClock,
   output logic            latchStrobe,
   output logic            busy
);
   logic [4:0] gsCnt;
   logic [3:0] latCnt;
   // Clock stands low between pulses; each phase lasts halfPer cycles
   assign grayscaleRefClock = gsCnt > {1'b0, halfPer};
   assign latchStrobe       = latCnt > 4'h4;
   assign busy              = gsCnt != 5'h00 || latCnt != 4'h0;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gsCnt  <= 5'h00;
         latCnt <= 4'h0;
      end else begin
         gsCnt  <= gsCnt != 5'h00 ? gsCnt - 5'h01 : (gsReq ? {halfPer, 1'b0} : 5'h00);
         latCnt <= latCnt != 4'h0 ? latCnt - 4'h1 : (latReq ? 4'h8 : 4'h0);
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        gsReq = 1'b0, latReq = 1'b0, busy, grayscale_ref_clock, latStrobe;
   logic [3:0]  halfPer = 4'h4;
   logic [15:0] sinkOutput;
   logic [15:0] vals [16];
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   int          miscompares = 0, nTests = 0;
   always #5 sys_clk = ~sys_clk;
   gspwm_host_model host (.sys_clk(sys_clk), .reset(reset), .gsReq(gsReq), .latReq(latReq),
      .halfPer(halfPer), .grayscaleRefClock(grayscale_ref_clock), .latchStrobe(latStrobe), .busy(busy));
   gspwm_sequencer dut (.sys_clk(sys_clk), .reset(reset), .grayscaleRefClock(grayscale_ref_clock),
      .latchStrobe(latStrobe), .sinkOutput(sinkOutput), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
      logic aDone, dDone;
      aDone = 1'b0;
      dDone = 1'b0;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aDone && dDone)) begin
         @(posedge sys_clk);
         if (awvalid && awready) begin aDone = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready) begin dDone = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, expResp}, {30'h0, bresp});
      // Let an edge pass so a following call never re-raises bready in this step
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] expData, input logic [1:0] expResp);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      check("rdata", expData, rdata);
      check("rresp", {30'h0, expResp}, {30'h0, rresp});
      @(posedge sys_clk);
   endtask
   task automatic pulse(input logic lat);
      if (lat) latReq <= 1'b1; else gsReq <= 1'b1;
      @(posedge sys_clk);
      latReq <= 1'b0; gsReq <= 1'b0;
      @(posedge sys_clk);
      while (busy) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
   endtask
   // Expected outputs after cnt grayscale clocks of the current period
   function automatic logic [15:0] expect_out(input logic spread, input int cnt);
      logic [15:0] res, pos;
      logic [6:0]  rev;
      pos = 16'(cnt - 1);
      for (int i = 0; i < 7; i++) rev[i] = pos[15 - i];
      for (int n = 0; n < 16; n++)
         res[n] = cnt != 0 && (spread ? {7'h0, pos[8:0]} < {7'h0, vals[n][15:7]} +
            {15'h0, rev < vals[n][6:0]} : pos < vals[n]);
      return res;
   endfunction
   task automatic load_values(input int mult);
      for (int n = 0; n < 16; n++) begin
         vals[n] = 16'(n * mult);
         wr(gspwm_pkg::GS_STAGE_BASE + 8'(4 * n), {16'h0, vals[n]}, 2'h0);
      end
      pulse(1'b1);
      rd(gspwm_pkg::GS_SHOWN_BASE + 8'h14, {16'h0, vals[5]}, 2'h0);
   endtask
   task automatic test_reset();
      rd(gspwm_pkg::CTRL_OFS, 32'h1, 2'h0);
      rd(gspwm_pkg::STATUS_OFS, 32'h0, 2'h0);
      check("sinkOutput", 32'h0, {16'h0, sinkOutput});
      rd(8'h08, 32'h0, 2'h2);
      wr(8'h3C, 32'h1, 2'h2);
   endtask
   task automatic test_plain();
      load_values(1);
      wr(gspwm_pkg::CTRL_OFS, 32'h0, 2'h0);
      rd(gspwm_pkg::STATUS_OFS, 32'h10000, 2'h0);
      for (int k = 1; k <= 17; k++) begin
         pulse(1'b0);
         check("sinkOutput", {16'h0, expect_out(1'b0, k)}, {16'h0, sinkOutput});
         rd(gspwm_pkg::STATUS_OFS, 32'h10000 + 32'(k), 2'h0);
      end
   endtask
   task automatic test_disable();
      wr(gspwm_pkg::CTRL_OFS, 32'h1, 2'h0);
      check("sinkOutput", 32'h0, {16'h0, sinkOutput});
      pulse(1'b0);
      rd(gspwm_pkg::STATUS_OFS, 32'h0, 2'h0);
   endtask
   task automatic test_spread();
      halfPer <= 4'h7;
      load_values(129);
      wr(gspwm_pkg::CTRL_OFS, 32'h2, 2'h0);
      for (int k = 1; k <= 4; k++) begin
         pulse(1'b0);
         check("sinkOutput", {16'h0, expect_out(1'b1, k)}, {16'h0, sinkOutput});
      end
      halfPer <= 4'h4;
   endtask
   task automatic test_restart();
      wr(gspwm_pkg::CTRL_OFS, 32'h1, 2'h0);
      wr(gspwm_pkg::CTRL_OFS, 32'h4, 2'h0);
      repeat (3) pulse(1'b0);
      rd(gspwm_pkg::STATUS_OFS, 32'h10003, 2'h0);
      pulse(1'b1);
      rd(gspwm_pkg::STATUS_OFS, 32'h10000, 2'h0);
      check("sinkOutput", 32'h0, {16'h0, sinkOutput});
      pulse(1'b0);
      check("sinkOutput", {16'h0, expect_out(1'b0, 1)}, {16'h0, sinkOutput});
      wr(gspwm_pkg::CTRL_OFS, 32'h1, 2'h0);
      check("sinkOutput", 32'h0, {16'h0, sinkOutput});
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && nTests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      test_reset();
      test_plain();
      test_disable();
      test_spread();
      test_restart();
      print_verdict();
   end
   // A hang costs this whole span of 20000 cycles; whole run needs about 650
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      print_verdict();
   end
endmodule
`default_nettype wire
